// file: sram_bus_consts.svh
// timing counts, burst layout and lane widths of the burst sram bus logic
`ifndef SRAM_BUS_CONSTS_SVH
`define SRAM_BUS_CONSTS_SVH

// words in one burst and the internal low address bits that walk them
`define BURST_WORDS 4
`define BURST_LO_BITS 2

// beat offsets within a burst
`define BEAT_WORD0 2'h0
`define BEAT_WORD1 2'h1
`define BEAT_WORD2 2'h2
`define BEAT_WORD3 2'h3

// lane widths: byte lanes on the 18 and 36 bit parts, nibbles on the 8 bit part
`define LANE_W_BYTE 9
`define LANE_W_NIBBLE 4

// input clock silence after which the core side reports standby
`define STOP_TIME_NS 100
`define CORE_PERIOD_NS 4
`define STOP_CYCLES ((`STOP_TIME_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)

// consecutive input clock edges with both output clocks high before they count as tied
`define TIED_SAMPLES 8

`endif

// file: sram_bus_pkg.sv
// state types of the burst sram bus logic
package sram_bus_pkg;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_LO,
    RD_HI
  } rd_state_e;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_LO,
    WR_HI
  } wr_state_e;

endpackage

// file: bit_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter int WIDTH = 1
) (
  // destination clock
  input wire logic clk,
  // level from another domain
  input wire logic [WIDTH-1:0] din,
  // synchronised level
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("bit_sync needs at least one bit");
    end
  endgenerate

  // the first stage is read by the second stage only
  always_ff @(posedge clk) begin
    meta_q <= din;
    dout <= meta_q;
  end

endmodule // bit_sync

`default_nettype wire

// file: dual_port_ddr_burst4_sram_bus.sv
// device-side bus-cycle logic of a four-word burst ddr sram with split data ports
`timescale 1ns/1ps
`default_nettype none
`include "sram_bus_consts.svh"

module dual_port_ddr_burst4_sram_bus #(
  parameter int DATA_W = 18,
  parameter int LANES = 2,
  parameter int ADDR_W = 18,
  parameter int STOP_CYCLES = `STOP_CYCLES
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // core-side status
  output logic read_busy,
  output logic write_busy,
  output logic clocks_stopped,
  // input clock pair
  input wire logic input_timing_pos,
  input wire logic input_timing_neg,
  // output clock pair, both tied high to launch on the input pair
  input wire logic output_timing_pos,
  input wire logic output_timing_neg,
  // request side
  input wire logic fetch_select_n,
  input wire logic store_select_n,
  input wire logic [ADDR_W-1:0] addr_bus,
  input wire logic [LANES-1:0] lane_mask_n,
  input wire logic [DATA_W-1:0] write_bus,
  // read side
  output logic [DATA_W-1:0] return_bus,
  output logic return_oe,
  output logic echo_timing_pos,
  output logic echo_timing_neg
);
  import sram_bus_pkg::*;

  localparam int LW = DATA_W / LANES;
  localparam int IDX_W = ADDR_W + `BURST_LO_BITS;
  localparam int DEPTH = 1 << IDX_W;
  localparam int CNT_W = $clog2(STOP_CYCLES + 1);
  localparam int TIE_W = $clog2(`TIED_SAMPLES + 1);

  generate
    if (!((DATA_W == 8 && LANES == 2 && LW == `LANE_W_NIBBLE) ||
          (DATA_W == 18 && LANES == 2 && LW == `LANE_W_BYTE) ||
          (DATA_W == 36 && LANES == 4 && LW == `LANE_W_BYTE))) begin : g_bad_shape
      $error("data width and lane count must be 8/2, 18/2 or 36/4");
    end
    if (ADDR_W < 1 || STOP_CYCLES < 1) begin : g_bad_count
      $error("address width and stop count must be positive");
    end
  endgenerate

  // storage
  logic [DATA_W-1:0] mem [DEPTH];

  // input clock domain
  logic link_rst;
  rd_state_e rd_state_q;
  wr_state_e wr_state_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [DATA_W-1:0] wd_pos_q;
  logic [LANES-1:0] wm_pos_q;
  logic rd_active_q;
  logic wr_active_q;
  logic [1:0] tie_sync;
  logic [TIE_W-1:0] tie_cnt_q;
  logic use_k_q;
  logic rd_take;
  logic wr_take;
  logic [LANES-1:0] we_a;
  logic [LANES-1:0] we_b;
  logic [IDX_W-1:0] idx_a;
  logic [IDX_W-1:0] idx_b;

  // negative input clock domain
  logic [ADDR_W-1:0] addr_neg_q;
  logic [DATA_W-1:0] wd_neg_q;
  logic [LANES-1:0] wm_neg_q;

  // launch domains
  logic launch_pos;
  logic launch_neg;
  logic tog_pos_q;
  logic tog_neg_q;
  logic oe_pos_q;
  logic oe_neg_q;
  logic [DATA_W-1:0] ret_pos_q;
  logic [DATA_W-1:0] ret_neg_q;
  logic phase_pos;
  logic rd_hi;

  // core domain
  logic [2:0] core_sync;
  logic k_seen_q;
  logic k_edge;
  logic [CNT_W-1:0] idle_cnt_q;
  logic clocks_stopped_q;
  logic read_busy_q;
  logic write_busy_q;

  // reset reaches the link side through a synchroniser on the input clock; the launch flops take it asynchronously
  bit_sync #(.WIDTH(1)) u_rst_sync (
    .clk(input_timing_pos),
    .din(sys_rst),
    .dout(link_rst)
  );

  // a select is refused while its machine sits in the first cycle of a burst
  assign rd_take = !fetch_select_n && rd_state_q != RD_LO;
  assign wr_take = !store_select_n && wr_state_q != WR_LO;

  always_ff @(posedge input_timing_pos) begin
    if (link_rst) begin
      rd_state_q <= RD_IDLE;
    end else begin
      case (rd_state_q)
        RD_IDLE: rd_state_q <= rd_take ? RD_LO : RD_IDLE;
        RD_LO: rd_state_q <= RD_HI;
        RD_HI: rd_state_q <= rd_take ? RD_LO : RD_IDLE;
        default: rd_state_q <= RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge input_timing_pos) begin
    if (link_rst) begin
      wr_state_q <= WR_IDLE;
    end else begin
      case (wr_state_q)
        WR_IDLE: wr_state_q <= wr_take ? WR_LO : WR_IDLE;
        WR_LO: wr_state_q <= WR_HI;
        WR_HI: wr_state_q <= wr_take ? WR_LO : WR_IDLE;
        default: wr_state_q <= WR_IDLE;
      endcase
    end
  end

  // addresses: read on the positive edge, write on the following negative edge
  always_ff @(posedge input_timing_pos) begin
    if (link_rst) begin
      rd_addr_q <= '0;
      wr_addr_q <= '0;
    end else begin
      if (rd_take) begin
        rd_addr_q <= addr_bus;
      end
      if (wr_state_q == WR_LO) begin
        wr_addr_q <= addr_neg_q;
      end
    end
  end

  always_ff @(posedge input_timing_pos) begin
    if (link_rst) begin
      rd_active_q <= 1'b0;
      wr_active_q <= 1'b0;
    end else begin
      rd_active_q <= rd_take || rd_state_q == RD_LO;
      wr_active_q <= wr_take || wr_state_q == WR_LO;
    end
  end

  // even beats and their masks; captured every positive edge, used only inside a write burst
  always_ff @(posedge input_timing_pos) begin
    wd_pos_q <= write_bus;
    wm_pos_q <= lane_mask_n;
  end

  // odd beats, masks and the write address; ignored unless a write claims them
  always_ff @(posedge input_timing_neg) begin
    addr_neg_q <= addr_bus;
    wd_neg_q <= write_bus;
    wm_neg_q <= lane_mask_n;
  end

  // words 0 and 1 retire at the first edge after the request, 2 and 3 at the second
  always_comb begin
    idx_a = '0;
    idx_b = '0;
    we_a = '0;
    we_b = '0;
    if (wr_state_q == WR_LO) begin
      idx_a = {addr_neg_q, `BEAT_WORD0};
      idx_b = {addr_neg_q, `BEAT_WORD1};
      we_a = ~wm_pos_q;
      we_b = ~wm_neg_q;
    end else if (wr_state_q == WR_HI) begin
      idx_a = {wr_addr_q, `BEAT_WORD2};
      idx_b = {wr_addr_q, `BEAT_WORD3};
      we_a = ~wm_pos_q;
      we_b = ~wm_neg_q;
    end
  end

  // two words retire per cycle, so the array has two write ports
  always_ff @(posedge input_timing_pos) begin
    for (int l = 0; l < LANES; l++) begin
      if (we_a[l]) begin
        mem[idx_a][l*LW +: LW] <= wd_pos_q[l*LW +: LW];
      end
      if (we_b[l]) begin
        mem[idx_b][l*LW +: LW] <= wd_neg_q[l*LW +: LW];
      end
    end
  end

  // output clocks count as tied only after a run of samples, so a running pair
  // whose overlap happens to be caught once does not switch the launch clock
  bit_sync #(.WIDTH(2)) u_tie_sync (
    .clk(input_timing_pos),
    .din({output_timing_pos, output_timing_neg}),
    .dout(tie_sync)
  );

  always_ff @(posedge input_timing_pos) begin
    if (link_rst) begin
      tie_cnt_q <= '0;
      use_k_q <= 1'b0;
    end else begin
      if (!(&tie_sync)) begin
        tie_cnt_q <= '0;
      end else if (tie_cnt_q != TIE_W'(`TIED_SAMPLES)) begin
        tie_cnt_q <= tie_cnt_q + TIE_W'(1);
      end
      use_k_q <= &tie_sync && tie_cnt_q == TIE_W'(`TIED_SAMPLES);
    end
  end

  // the tie is a board strap; toggling it while running glitches the launch clocks
  assign launch_pos = use_k_q ? input_timing_pos : output_timing_pos;
  assign launch_neg = use_k_q ? input_timing_neg : output_timing_neg;
  assign rd_hi = rd_state_q == RD_HI;

  // each launch edge sees the read machine before the next positive update;
  // launch clocks may be parked during reset, so the launch flops clear without them
  always_ff @(posedge launch_neg or posedge link_rst) begin
    if (link_rst) begin
      tog_neg_q <= 1'b0;
      oe_neg_q <= 1'b0;
      ret_neg_q <= '0;
    end else begin
      tog_neg_q <= tog_pos_q;
      oe_neg_q <= rd_state_q != RD_IDLE;
      ret_neg_q <= mem[{rd_addr_q, rd_hi, 1'b0}];
    end
  end

  always_ff @(posedge launch_pos or posedge link_rst) begin
    if (link_rst) begin
      tog_pos_q <= 1'b0;
      oe_pos_q <= 1'b0;
      ret_pos_q <= '0;
    end else begin
      tog_pos_q <= ~tog_neg_q;
      oe_pos_q <= rd_state_q != RD_IDLE;
      ret_pos_q <= mem[{rd_addr_q, rd_hi, 1'b1}];
    end
  end

  // toggles differ after a positive launch edge and agree after a negative one
  assign phase_pos = tog_pos_q ^ tog_neg_q;
  assign return_bus = phase_pos ? ret_pos_q : ret_neg_q;
  assign return_oe = !link_rst && (phase_pos ? oe_pos_q : oe_neg_q);
  assign echo_timing_pos = phase_pos;
  assign echo_timing_neg = ~phase_pos;

  // core side watches activity and the input clock itself
  bit_sync #(.WIDTH(3)) u_core_sync (
    .clk(core_clk),
    .din({rd_active_q, wr_active_q, input_timing_pos}),
    .dout(core_sync)
  );

  assign k_edge = core_sync[0] ^ k_seen_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      k_seen_q <= 1'b0;
      idle_cnt_q <= '0;
      clocks_stopped_q <= 1'b0;
    end else begin
      k_seen_q <= core_sync[0];
      if (k_edge) begin
        idle_cnt_q <= '0;
      end else if (idle_cnt_q != CNT_W'(STOP_CYCLES)) begin
        idle_cnt_q <= idle_cnt_q + CNT_W'(1);
      end
      clocks_stopped_q <= !k_edge && idle_cnt_q == CNT_W'(STOP_CYCLES);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      read_busy_q <= 1'b0;
      write_busy_q <= 1'b0;
    end else begin
      read_busy_q <= core_sync[2];
      write_busy_q <= core_sync[1];
    end
  end

  assign read_busy = read_busy_q;
  assign write_busy = write_busy_q;
  assign clocks_stopped = clocks_stopped_q;

  // checks on the input clock domain, and one on the core clock for the stop flag
  sequence s_rd_burst;
    rd_state_q == RD_LO ##1 rd_state_q == RD_HI;
  endsequence

  sequence s_wr_burst;
    wr_state_q == WR_LO ##1 wr_state_q == WR_HI;
  endsequence

  AST_RD_BURST: assert property (
    @(posedge input_timing_pos) disable iff (link_rst)
    rd_take |=> s_rd_burst
  ) else $error("read burst did not run for two cycles");

  AST_WR_BURST: assert property (
    @(posedge input_timing_pos) disable iff (link_rst)
    wr_take |=> s_wr_burst
  ) else $error("write burst did not run for two cycles");

  AST_RD_REPEAT: assert property (
    @(posedge input_timing_pos) disable iff (link_rst)
    (rd_state_q == RD_LO && !fetch_select_n) |=> (rd_state_q == RD_HI && $stable(rd_addr_q))
  ) else $error("second read on the next edge was not ignored");

  AST_WR_REPEAT: assert property (
    @(posedge input_timing_pos) disable iff (link_rst)
    (wr_state_q == WR_LO && !store_select_n) |=> wr_state_q == WR_HI
  ) else $error("second write on the next edge was not ignored");

  AST_CONCURRENT: assert property (
    @(posedge input_timing_pos) disable iff (link_rst)
    (rd_take && wr_take) |=> (s_rd_burst and s_wr_burst)
  ) else $error("read and write did not run together");

  AST_WR_ADDR: assert property (
    @(posedge input_timing_pos) disable iff (link_rst)
    wr_state_q == WR_LO |=> wr_addr_q == $past(addr_neg_q)
  ) else $error("write address not taken from the negative edge");

  AST_NOP: assert property (
    @(posedge input_timing_pos) disable iff (link_rst)
    (fetch_select_n && store_select_n && rd_state_q != RD_LO && wr_state_q != WR_LO)
      |=> (rd_state_q == RD_IDLE && wr_state_q == WR_IDLE)
  ) else $error("transaction started with both selects high");

  AST_MASK_ALL_HIGH: assert property (
    @(posedge input_timing_pos) disable iff (link_rst)
    (wr_state_q == WR_LO && (&wm_pos_q) && (&wm_neg_q))
      |-> (we_a == '0 && we_b == '0) ##1 wr_state_q == WR_HI
  ) else $error("masked beats stored data or stalled the burst");

  AST_MASK_IDLE: assert property (
    @(posedge input_timing_pos) disable iff (link_rst)
    wr_state_q == WR_IDLE |-> (we_a == '0 && we_b == '0)
  ) else $error("store outside a write burst");

  AST_ALTERNATE: assert property (
    @(posedge input_timing_pos) disable iff (link_rst)
    (rd_state_q == RD_HI && !fetch_select_n) |=> rd_state_q == RD_LO
  ) else $error("back-to-back read burst was refused");

  AST_OE_RESET: assert property (
    @(posedge input_timing_pos)
    link_rst |-> !return_oe
  ) else $error("return bus driven during reset");

  AST_STOP_FLAG: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (idle_cnt_q == CNT_W'(STOP_CYCLES) && !k_edge) |=> clocks_stopped_q ##0 $stable(idle_cnt_q)
  ) else $error("stopped input clock not flagged");

endmodule // dual_port_ddr_burst4_sram_bus

`default_nettype wire

// file: sram_ctl_model.sv
// controller model: input clock pair, burst requests and read sampling
`timescale 1ns/1ps
`default_nettype none

module sram_ctl_model (
  // clocks toward the device
  output logic k,
  output logic kn,
  output logic c,
  output logic cn,
  // requests
  output logic fetch_n,
  output logic store_n,
  output logic [17:0] addr,
  output logic [1:0] mask_n,
  output logic [17:0] wdata,
  // read return
  input wire logic [17:0] rdata,
  input wire logic roe
);
  logic run;

  initial begin
    {k, kn, c, cn} = 4'h7; // output pair tied high: launch on the input pair
    {fetch_n, store_n, run} = 3'h7;
    addr = 18'h0_0000;
    mask_n = 2'h3;
    wdata = 18'h0_0000;
    #0.7;
    forever #24 if (run) begin
      k = ~k;
      kn = ~k;
    end
  end

  task automatic halt(input logic stop);
    if (stop) begin
      @(posedge k);
      run = 1'b0;
      #24 kn = 1'b1; // all four clocks parked at the same level
    end else begin
      run = 1'b1;
    end
  endtask

  // one slot; hold keeps the selects low one edge more, which must be refused
  task automatic op(input logic rd, wr, hold, input logic [17:0] ra, wa,
      input logic [71:0] wd, input logic [7:0] wm,
      output logic [71:0] q, output logic [4:0] oe);
    @(posedge k) #1;
    fetch_n = ~rd;
    store_n = ~wr;
    addr = ra;
    wdata = wd[17:0];
    mask_n = wm[1:0];
    @(posedge k) #1;
    fetch_n = ~(rd & hold);
    store_n = ~(wr & hold);
    addr = wa;
    wdata = wd[35:18];
    mask_n = wm[3:2];
    @(posedge kn) #1;
    {q[17:0], oe[0]} = {rdata, roe};
    addr = ~wa;
    wdata = wd[53:36];
    mask_n = wm[5:4];
    @(posedge k) #1;
    {q[35:18], oe[1]} = {rdata, roe};
    {fetch_n, store_n} = 2'h3;
    wdata = wd[71:54];
    mask_n = wm[7:6];
    @(posedge kn) #1;
    {q[53:36], oe[2]} = {rdata, roe};
    // released lines flip so a stale value is never mistaken for a beat
    wdata = ~wdata;
    mask_n = ~mask_n;
    @(posedge k) #1;
    {q[71:54], oe[3]} = {rdata, roe};
    @(posedge kn) #1;
    oe[4] = roe;
  endtask
endmodule // sram_ctl_model

`default_nettype wire

// file: test_dual_port_ddr_burst4_sram_bus.sv
// self-checking bench: bursts, lane masks, refusals, nop and clock-stop standby
`timescale 1ns/1ps
`default_nettype none

module test_dual_port_ddr_burst4_sram_bus;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  wire logic k, kn, c, cn, fetch_n, store_n, roe;
  wire logic read_busy, write_busy, clocks_stopped, echo, echo_n;
  wire logic [17:0] addr, wdata, rdata;
  wire logic [1:0] mask_n;
  int err_count = 0;
  int checks = 0;
  logic [17:0] mem [int];

  always #2 core_clk = ~core_clk;

  // short standby threshold keeps the clock-stop wait brief
  dual_port_ddr_burst4_sram_bus #(.STOP_CYCLES(4)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .read_busy(read_busy),
    .write_busy(write_busy), .clocks_stopped(clocks_stopped),
    .input_timing_pos(k), .input_timing_neg(kn),
    .output_timing_pos(c), .output_timing_neg(cn),
    .fetch_select_n(fetch_n), .store_select_n(store_n), .addr_bus(addr),
    .lane_mask_n(mask_n), .write_bus(wdata), .return_bus(rdata),
    .return_oe(roe), .echo_timing_pos(echo), .echo_timing_neg(echo_n)
  );

  sram_ctl_model ctl (
    .k(k), .kn(kn), .c(c), .cn(cn), .fetch_n(fetch_n), .store_n(store_n),
    .addr(addr), .mask_n(mask_n), .wdata(wdata), .rdata(rdata), .roe(roe)
  );

  task automatic chk(input string what, input logic [71:0] exp, got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic go(input logic rd, wr, hold, input logic [17:0] ra, wa,
      input logic [71:0] wd, input logic [7:0] wm);
    logic [71:0] q, e;
    logic [4:0] oe;
    if (rd)
      for (int i = 0; i < 4; i++)
        e[18*i +: 18] = mem[{ra, 2'(i)}];
    ctl.op(rd, wr, hold, ra, wa, wd, wm, q, oe);
    if (wr)
      for (int i = 0; i < 4; i++)
        for (int j = 0; j < 2; j++)
          if (!wm[2*i+j])
            mem[{wa, 2'(i)}][9*j +: 9] = wd[18*i+9*j +: 9];
    if (rd)
      chk("read burst", e, q);
    chk("return enable", 72'({1'b0, {4{rd}}}), 72'(oe));
  endtask

  task automatic t_burst();
    bit ws, rs;
    fork
      go(1'b0, 1'b1, 1'b0, 18'h0_0000, 18'h0_0001, 72'h01_2345_6789_abcd_ef01, 8'h00);
      repeat (60) @(posedge core_clk) ws |= (write_busy === 1'b1);
    join
    chk("write busy", 72'h1, 72'(ws));
    fork
      go(1'b1, 1'b0, 1'b0, 18'h0_0001, 18'h0_0000, 72'h0, 8'hff);
      repeat (60) @(posedge core_clk) rs |= (read_busy === 1'b1);
    join
    chk("read busy", 72'h1, 72'(rs));
    $display("test burst done");
  endtask

  task automatic t_mask();
    go(1'b0, 1'b1, 1'b0, 18'h0_0000, 18'h0_0001, 72'hfe_dcba_9876_5432_10fe, 8'h36);
    go(1'b1, 1'b0, 1'b0, 18'h0_0001, 18'h0_0000, 72'h0, 8'hff);
    $display("test mask done");
  endtask

  task automatic t_refuse();
    // read and write start on one edge, both selects left low one edge too long
    go(1'b1, 1'b1, 1'b1, 18'h0_0001, 18'h0_0002, 72'h5a_5a5a_a5a5_3c3c_c3c3, 8'h00);
    go(1'b1, 1'b0, 1'b0, 18'h0_0002, 18'h0_0000, 72'h0, 8'hff);
    $display("test refuse done");
  endtask

  task automatic t_nop();
    go(1'b0, 1'b0, 1'b0, 18'h0_0002, 18'h0_0002, 72'hff_ffff_ffff_ffff_ffff, 8'h00);
    go(1'b1, 1'b0, 1'b0, 18'h0_0002, 18'h0_0000, 72'h0, 8'hff);
    // echo pair keeps running with the bus released
    @(posedge k) #1;
    chk("echo after pos edge", 72'h2, 72'({echo, echo_n}));
    @(posedge kn) #1;
    chk("echo after neg edge", 72'h1, 72'({echo, echo_n}));
    $display("test nop done");
  endtask

  task automatic t_standby();
    int n;
    ctl.halt(1'b1);
    n = 0;
    while (clocks_stopped !== 1'b1 && n < 80) begin
      @(posedge core_clk);
      n++;
    end
    chk("standby flag", 72'h1, 72'(clocks_stopped));
    ctl.halt(1'b0);
    repeat (12) @(posedge k);
    chk("standby cleared", 72'h0, 72'(clocks_stopped));
    go(1'b1, 1'b0, 1'b0, 18'h0_0001, 18'h0_0000, 72'h0, 8'hff);
    go(1'b1, 1'b0, 1'b0, 18'h0_0002, 18'h0_0000, 72'h0, 8'hff);
    $display("test standby done");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    // the link side sees reset only after its own sync on the input clock
    repeat (3) @(posedge k);
    chk("idle in reset", 72'h0, 72'({roe, read_busy, write_busy}));
    @(posedge core_clk) #1 sys_rst = 1'b0;
    // the tied output pair needs several input edges before it counts
    repeat (12) @(posedge k);
    t_burst();
    t_mask();
    t_refuse();
    t_nop();
    t_standby();
    wrap_up();
  end
endmodule // test_dual_port_ddr_burst4_sram_bus

`default_nettype wire
